// ===== core/egp_edge_line.sv
// One port line's edge detector and pending flag.
// Assumes the line sample given here is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module egp_edge_line (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic sample,
  input  wire logic rising_sel,
  input  wire logic enable,
  input  wire logic clear,
  output var  logic pending
);

  logic prev;
  logic hit;

  // Compare successive synchronised samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= sample; // RULE11
    end
  end

  assign hit = rising_sel ? (sample & ~prev) : (~sample & prev); // RULE2 RULE11

  // Set wins over clear; masking does not drop the event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (ce) begin
      if (hit && enable) begin
        pending <= 1'b1; // RULE10
      end else if (clear || !enable) begin
        pending <= 1'b0;
      end
    end
  end

endmodule // egp_edge_line
`default_nettype wire

// ===== core/egp_pkg.sv
// Package of the eight-line edge interrupt I/O port: register offsets,
// reset values, field positions and shared types.
// Assumes an 8-bit register bus with a 4-bit register address.
package egp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] REG_PORT_LINE_DATA      = 4'h1;
  localparam logic [3:0] REG_EDGE_POLARITY       = 4'h3;
  localparam logic [3:0] REG_LINE_DIRECTION      = 4'h5;
  localparam logic [3:0] REG_LINE_PENDING        = 4'h2;
  localparam logic [3:0] REG_LINE_ENABLE         = 4'h4;
  localparam logic [3:0] REG_LINE_MASK           = 4'h6;

  localparam logic [7:0] RST_REG                 = 8'h00;
  localparam logic [7:0] READ_UNMAPPED           = 8'h00;

  // ****************************************************************
  // Line roles
  // ****************************************************************
  localparam int LINE_RECEIVE_FULL   = 0;
  localparam int LINE_TRANSMIT_EMPTY = 1;
  localparam int LINE_TIMER_B        = 3;
  localparam int LINE_TIMER_A        = 4;
  localparam int NUM_LINES           = 8;

  localparam logic [3:0] CHANNEL_NONE = 4'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } egp_bus_req_t;

  typedef struct packed {
    logic receive_full_handshake;
    logic transmit_empty_handshake;
    logic dma_enable;
  } egp_serial_t;

endpackage : egp_pkg

// ===== core/egp_port.sv
// Eight-line general purpose I/O port with per-line edge interrupts.
// Assumes an 8-bit CPU-style register bus sampled on clk, port line
// pins asynchronous to clk, serial handshake and timer modes from
// neighbouring logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: Direction bit per line, 1 output
// RULE2: Edge bit per line, 1 rising
// RULE3: Data reads line levels, writes drive outputs
// RULE4: Lines 0/1 output receive-full, transmit-empty handshakes
// RULE5: Handshake mode overrides data and direction
// RULE6: Line 4 feeds timer A, 3 timer B
// RULE7: Timer inputs held four timer clocks each level
// RULE8: Enabled unmasked edge asserts open-drain interrupt low
// RULE9: Line 7 highest channel, line 0 lowest
// RULE10: Masked events stay pending until unmasked
// RULE11: Synchronised inputs, one event per transition
module egp_port #(
  parameter int LINES = egp_pkg::NUM_LINES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire egp_pkg::egp_bus_req_t bus_req,
  output logic [7:0]                bus_rdata,
  input  wire egp_pkg::egp_serial_t serial_in,
  input  wire logic                 timer_a_ext_mode,
  input  wire logic                 timer_b_ext_mode,
  input  wire logic [LINES-1:0]     port_lines_in,
  output logic [LINES-1:0]          port_lines_out,
  output logic [LINES-1:0]          port_lines_oe,
  output logic                      timer_a_input,
  output logic                      timer_b_input,
  output logic                      irq_n_out,
  output logic                      irq_n_oe,
  output logic [3:0]                irq_channel
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [LINES-1:0] port_line_data;
  logic [LINES-1:0] edge_polarity_select;
  logic [LINES-1:0] line_direction_select;
  logic [LINES-1:0] line_enable;
  logic [LINES-1:0] line_mask;
  logic [LINES-1:0] sync_a;
  logic [LINES-1:0] sync_b;
  logic [LINES-1:0] pending;
  logic [LINES-1:0] clear_req;
  logic [LINES-1:0] next_out;
  logic [LINES-1:0] next_oe;
  logic [LINES-1:0] presented;
  logic [3:0]       next_channel;
  logic [3:0]       line_code [LINES];
  logic [7:0]       next_rdata;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_line_data        <= egp_pkg::RST_REG;
      edge_polarity_select  <= egp_pkg::RST_REG;
      line_direction_select <= egp_pkg::RST_REG;
      line_enable           <= egp_pkg::RST_REG;
      line_mask             <= egp_pkg::RST_REG;
    end else if (ce && bus_req.wr) begin
      unique case (bus_req.addr)
        egp_pkg::REG_PORT_LINE_DATA: port_line_data        <= bus_req.wdata; // RULE3
        egp_pkg::REG_EDGE_POLARITY:  edge_polarity_select  <= bus_req.wdata; // RULE2
        egp_pkg::REG_LINE_DIRECTION: line_direction_select <= bus_req.wdata; // RULE1
        egp_pkg::REG_LINE_ENABLE:    line_enable           <= bus_req.wdata;
        egp_pkg::REG_LINE_MASK:      line_mask             <= bus_req.wdata; // RULE10
        default: ;
      endcase
    end
  end

  // Pending register: writing 0 clears, writing 1 leaves unchanged
  assign clear_req = (ce && bus_req.wr && bus_req.addr == egp_pkg::REG_LINE_PENDING)
                     ? ~bus_req.wdata : '0;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce) begin
      sync_a <= port_lines_in; // RULE11
      sync_b <= sync_a;
    end
  end

  // ****************************************************************
  // Edge detection per line
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      egp_edge_line u_edge (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .sample     (sync_b[g]),
        .rising_sel (edge_polarity_select[g]),
        .enable     (line_enable[g]),
        .clear      (clear_req[g]),
        .pending    (pending[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Pin drive with handshake override
  // ****************************************************************
  always_comb begin
    next_out = port_line_data;
    next_oe  = line_direction_select; // RULE1
    if (serial_in.dma_enable) begin
      next_out[egp_pkg::LINE_RECEIVE_FULL]   = serial_in.receive_full_handshake;   // RULE4 RULE5
      next_out[egp_pkg::LINE_TRANSMIT_EMPTY] = serial_in.transmit_empty_handshake; // RULE4 RULE5
      next_oe[egp_pkg::LINE_RECEIVE_FULL]    = 1'b1; // RULE5
      next_oe[egp_pkg::LINE_TRANSMIT_EMPTY]  = 1'b1; // RULE5
    end
  end

  // ****************************************************************
  // Channel code of each line; the codes in between belong to timer
  // and serial events that this block does not raise
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      unique case (i)
        0:       line_code[i] = 4'h0;
        1:       line_code[i] = 4'h1;
        2:       line_code[i] = 4'h2;
        3:       line_code[i] = 4'h3;
        4:       line_code[i] = 4'h6;
        5:       line_code[i] = 4'h7;
        6:       line_code[i] = 4'hE;
        default: line_code[i] = 4'hF;
      endcase
    end
  end

  // ****************************************************************
  // Priority channel of highest unmasked pending line
  // ****************************************************************
  assign presented = pending & line_mask; // RULE10

  always_comb begin
    next_channel = egp_pkg::CHANNEL_NONE;
    for (int i = 0; i < LINES; i++) begin
      if (presented[i]) begin
        next_channel = line_code[i]; // RULE9
      end
    end
  end

  // ****************************************************************
  // Pin drive registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_lines_out <= '0;
      port_lines_oe  <= '0;
    end else if (ce) begin
      port_lines_out <= next_out;
      port_lines_oe  <= next_oe;
    end
  end

  // ****************************************************************
  // Timer inputs, gated by the timers' external modes
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_input <= 1'b0;
      timer_b_input <= 1'b0;
    end else if (ce) begin
      timer_a_input <= timer_a_ext_mode & sync_b[egp_pkg::LINE_TIMER_A]; // RULE6
      timer_b_input <= timer_b_ext_mode & sync_b[egp_pkg::LINE_TIMER_B]; // RULE6
    end
  end

  // ****************************************************************
  // Interrupt request: the pin is only ever pulled low
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_out   <= 1'b0;
      irq_n_oe    <= 1'b0;
      irq_channel <= egp_pkg::CHANNEL_NONE;
    end else if (ce) begin
      irq_n_out   <= 1'b0;
      irq_n_oe    <= |presented; // RULE8
      irq_channel <= next_channel; // RULE9
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    next_rdata = egp_pkg::READ_UNMAPPED;
    unique case (bus_req.addr)
      egp_pkg::REG_PORT_LINE_DATA: next_rdata = sync_b; // RULE3
      egp_pkg::REG_EDGE_POLARITY:  next_rdata = edge_polarity_select;
      egp_pkg::REG_LINE_DIRECTION: next_rdata = line_direction_select;
      egp_pkg::REG_LINE_PENDING:   next_rdata = pending;
      egp_pkg::REG_LINE_ENABLE:    next_rdata = line_enable;
      egp_pkg::REG_LINE_MASK:      next_rdata = line_mask;
      default:                     next_rdata = egp_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= egp_pkg::READ_UNMAPPED;
    end else if (ce && bus_req.rd) begin
      bus_rdata <= next_rdata;
    end
  end

endmodule // egp_port
`default_nettype wire

// ===== test/egp_line_model.sv
// Outside devices on the eight port lines.
// Assumes the bench sets the level each device drives when released.
`timescale 1ns/1ps
`default_nettype none
module egp_line_model (
  input  wire logic [7:0] drv_out,
  input  wire logic [7:0] drv_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] lines
);
  // Driven lines follow the port, released ones the outside device
  assign lines = (drv_oe & drv_out) | (~drv_oe & ext_level);
endmodule // egp_line_model
`default_nettype wire

// ===== test/egp_port_assertions.sv
// Concurrent checks of the edge interrupt I/O port, bound to egp_port.
// Assumes only the ports of egp_port and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module egp_port_assertions #(
  parameter int LINES = 8
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  input wire egp_pkg::egp_bus_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire egp_pkg::egp_serial_t  serial_in,
  input wire logic                  timer_a_ext_mode,
  input wire logic                  timer_b_ext_mode,
  input wire logic [LINES-1:0]      port_lines_in,
  input wire logic [LINES-1:0]      port_lines_out,
  input wire logic [LINES-1:0]      port_lines_oe,
  input wire logic                  timer_a_input,
  input wire logic                  timer_b_input,
  input wire logic                  irq_n_out
);
  // ****************************************************************
  // Port rules
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_dir_wr;
    ce && bus_req.wr && bus_req.addr == egp_pkg::REG_LINE_DIRECTION;
  endsequence
  sequence s_pin4_steady;
    (ce && timer_a_ext_mode && $stable(port_lines_in[4]))[*5];
  endsequence
  a_irq_open_drain: assert property (!irq_n_out)
    else $error("irq drive level not low");
  a_dir_drive: assert property (s_dir_wr ##1 ce[*2] |->
    port_lines_oe[7:2] == $past(bus_req.wdata[7:2], 2)) else $error("dir not applied");
  a_dma_override: assert property (ce && serial_in.dma_enable |=>
    port_lines_oe[1:0] == 2'b11 && port_lines_out[1:0] == $past({
    serial_in.transmit_empty_handshake, serial_in.receive_full_handshake}))
    else $error("handshake not on lines 0 and 1");
  a_timer_a_gate: assert property (ce && !timer_a_ext_mode |=> !timer_a_input)
    else $error("timer a input not gated");
  a_timer_b_gate: assert property (ce && !timer_b_ext_mode |=> !timer_b_input)
    else $error("timer b input not gated");
  a_timer_a_follow: assert property (s_pin4_steady |->
    timer_a_input == port_lines_in[4]) else $error("timer a input not line 4");
  a_rdata_hold: assert property (!(ce && bus_req.rd) |=> $stable(bus_rdata))
    else $error("read data changed without read");
  a_unmapped_read: assert property (ce && bus_req.rd &&
    bus_req.addr inside {4'h0, [4'h7:4'hF]} |=> bus_rdata == egp_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
endmodule // egp_port_assertions

bind egp_port egp_port_assertions #(.LINES(LINES)) u_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .serial_in(serial_in), .timer_a_ext_mode(timer_a_ext_mode),
  .timer_b_ext_mode(timer_b_ext_mode), .port_lines_in(port_lines_in),
  .port_lines_out(port_lines_out), .port_lines_oe(port_lines_oe),
  .timer_a_input(timer_a_input), .timer_b_input(timer_b_input), .irq_n_out(irq_n_out));
`default_nettype wire

// ===== test/tb_egp_port.sv
// Self-checking bench of the edge interrupt I/O port.
// Assumes egp_pkg, egp_port, the line model and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_egp_port;
  logic clk, rst_n, ce, ma, mb, ta, tb, irq_oe;
  egp_pkg::egp_bus_req_t req;
  egp_pkg::egp_serial_t ser;
  logic [7:0] rdata, lines, p_out, p_oe, ext;
  logic [3:0] chan;
  int error_cnt, cmp_count;
  logic [19:0] rows [8] = '{20'h5FFFF, 20'h1A5A5, 20'h33C3C, 20'h68181,
    20'h40000, 20'h07700, 20'h50000, 20'h15A01};
  egp_port dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(req), .bus_rdata(rdata),
    .serial_in(ser), .timer_a_ext_mode(ma), .timer_b_ext_mode(mb),
    .port_lines_in(lines), .port_lines_out(p_out), .port_lines_oe(p_oe),
    .timer_a_input(ta), .timer_b_input(tb), .irq_n_out(),
    .irq_n_oe(irq_oe), .irq_channel(chan));
  egp_line_model u_lines (.drv_out(p_out), .drv_oe(p_oe), .ext_level(ext), .lines(lines));
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    logic [7:0] v;
    rst_n = 1'b0; req = '0; ser = '0; ma = 1'b0; mb = 1'b0; ext = 8'h01;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk("oe", 8'h00, p_oe | {7'h00, irq_oe});
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      repeat (4) @(posedge clk);
      rd(rows[i][19:16], v);
      chk("reg", rows[i][7:0], v);
    end
    $display("register test done");
    wr(4'h6, 8'h00);
    wr(4'h3, 8'h80);
    wr(4'h4, 8'hFF);
    ext <= 8'h80;
    repeat (6) @(posedge clk);
    chk("irq", 8'h00, {3'h0, irq_oe, chan});
    rd(4'h2, v);
    chk("pend", 8'h81, v);
    wr(4'h6, 8'hFF);
    repeat (2) @(posedge clk);
    chk("irq", 8'h1F, {3'h0, irq_oe, chan});
    wr(4'h2, 8'h7F);
    repeat (2) @(posedge clk);
    chk("irq", 8'h10, {3'h0, irq_oe, chan});
    ext <= 8'h01;
    repeat (6) @(posedge clk);
    rd(4'h2, v);
    chk("pend", 8'h01, v);
    wr(4'h2, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", 8'h00, {3'h0, irq_oe, chan});
    $display("interrupt test done");
    ser <= '{1'b1, 1'b0, 1'b1};
    repeat (3) @(posedge clk);
    chk("dma", 8'h0D, {4'h0, p_oe[1:0], p_out[1:0]});
    ser <= '0;
    $display("handshake test done");
    ma <= 1'b1;
    ext <= 8'h19; // Levels held far beyond four timer clocks
    repeat (6) @(posedge clk);
    chk("tmr", 8'h01, {6'h00, tb, ta});
    mb <= 1'b1;
    repeat (2) @(posedge clk);
    chk("tmr", 8'h03, {6'h00, tb, ta});
    $display("timer test done");
    ext <= 8'h11;
    repeat (6) @(posedge clk);
    chk("irq", 8'h13, {3'h0, irq_oe, chan});
    ext <= 8'h01;
    repeat (6) @(posedge clk);
    chk("irq", 8'h16, {3'h0, irq_oe, chan});
    $display("priority test done");
    ce <= 1'b0;
    wr(4'h5, 8'hFF);
    ce <= 1'b1;
    rd(4'h5, v);
    chk("ce", 8'h00, v);
    $display("clock enable test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("rst", 8'h00, {3'h0, irq_oe, chan});
    rd(4'h6, v);
    chk("rst", 8'h00, v);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule // tb_egp_port
`default_nettype wire
